// ==== hdl/adc_request_sequencer_pkg.sv ====
/*
 * constants for the converter request sequencer: register offsets, field
 * positions, reset values and state codes.
 * assumes a 32-bit axi4-lite register bus and a 50 MHz aclk.
 */
`default_nettype none
package adc_request_sequencer_pkg;
	localparam int NCONV  = 2;     // converter_first is index 0, converter_second index 1
	localparam int NRES   = 8;     // result registers per converter
	localparam int QDEPTH = 4;     // queued request entries per converter
	localparam int RES_W  = 10;    // full resolution
	localparam int ACC_W  = 16;    // result register width, room to accumulate
	localparam logic [4:0]  CHAN_COUNT [NCONV] = '{5'd11, 5'd5};
	localparam logic [15:0] CHAN_MASK  [NCONV] = '{16'h07FF, 16'h001F};
	localparam logic [3:0]  LAST_BIT_FULL  = 4'h0;  // sar walks down to bit 0
	localparam logic [3:0]  LAST_BIT_SHORT = 4'h2;  // 8-bit mode stops at bit 2
	localparam logic [9:0]  SAR_FIRST      = 10'h200;
	// address map, byte addresses
	localparam int ADDR_W    = 12;
	localparam int CONV_BIT  = 7;  // selects converter block, stride 0x80
	localparam int GLOB_BIT  = 8;  // global block at 0x100
	localparam logic [6:0] OFF_CTRL     = 7'h00;
	localparam logic [6:0] OFF_TIMING   = 7'h04;
	localparam logic [6:0] OFF_PAR_MASK = 7'h08;
	localparam logic [6:0] OFF_START    = 7'h0C;
	localparam logic [6:0] OFF_INSERT   = 7'h10;
	localparam logic [6:0] OFF_QUEUE    = 7'h14;
	localparam logic [6:0] OFF_LIMIT    = 7'h18;
	localparam logic [6:0] OFF_STATUS   = 7'h1C;
	localparam logic [6:0] OFF_WFR      = 7'h20;
	localparam logic [6:0] OFF_FIFO_OUT = 7'h24;
	localparam logic [6:0] OFF_RESULT   = 7'h40;  // eight words up to 0x5C
	localparam logic [6:0] OFF_DIDIS_A  = 7'h00;  // global block
	localparam logic [6:0] OFF_DIDIS_B  = 7'h04;
	localparam logic [6:0] OFF_SYNC     = 7'h08;
	// control register fields
	localparam int CTRL_RES8 = 0;
	localparam int CTRL_FIFO = 1;
	localparam int CTRL_ACC  = 2;
	localparam int CTRL_TRIG = 4;   // two bits
	localparam int CTRL_PRIO = 8;   // two bits per source: parallel, queue, insert
	localparam int CTRL_SRQ_RES = 14;
	localparam int CTRL_SRQ_LIM = 15;
	localparam int CTRL_XFER    = 16;
	localparam logic [31:0] CTRL_WMASK   = 32'h0001_FF37;
	localparam logic [31:0] TIMING_WMASK = 32'h0000_FFFF;
	localparam logic [31:0] LIMIT_WMASK  = 32'h03FF_03FF;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam logic [31:0] TIMING_RESET = 32'h0000_0204;  // step 2, sample 4
	localparam logic [31:0] LIMIT_RESET  = 32'h03FF_0000;  // high 0x3FF, low 0
	localparam logic [1:0] TRIG_SW = 2'h0, TRIG_EXT = 2'h1, TRIG_INT = 2'h2, TRIG_ANY = 2'h3;
	localparam logic [1:0] SRC_PAR = 2'h0, SRC_QUEUE = 2'h1, SRC_INS = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0, RESP_SLVERR = 2'h2;
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_SAMPLE = 4'b0010,
		ST_CONV   = 4'b0100,
		ST_STORE  = 4'b1000
	} conv_state_e;
endpackage
`default_nettype wire

// ==== hdl/adc_request_sequencer.sv ====
/*
 * request arbitration and successive-approximation control for two converters,
 * with result registers, limit check, accumulation and an axi4-lite slave.
 * assumes an external comparator and dac per converter, analog multiplexers
 * driven from chan_sel, and a transfer controller on the xfer handshake.
 */
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`default_nettype none
module adc_request_sequencer
	import adc_request_sequencer_pkg::*;
(
	input  wire logic              aclk,                           // 50 MHz clock
	input  wire logic              aresetn,                        // sync reset, low
	input  wire logic [ADDR_W-1:0] awaddr,                         // write address
	input  wire logic [2:0]        awprot,                         // unused
	input  wire logic              awvalid,                        // write address valid
	output logic                   awready,                        // write address ready
	input  wire logic [31:0]       wdata,                          // write data
	input  wire logic [3:0]        wstrb,                          // byte enables
	input  wire logic              wvalid,                         // write data valid
	output logic                   wready,                         // write data ready
	output logic [1:0]             bresp,                          // write response
	output logic                   bvalid,                         // write response valid
	input  wire logic              bready,                         // write response ready
	input  wire logic [ADDR_W-1:0] araddr,                         // read address
	input  wire logic [2:0]        arprot,                         // unused
	input  wire logic              arvalid,                        // read address valid
	output logic                   arready,                        // read address ready
	output logic [31:0]            rdata,                          // read data
	output logic [1:0]             rresp,                          // read response
	output logic                   rvalid,                         // read data valid
	input  wire logic              rready,                         // read data ready
	input  wire logic [NCONV-1:0]  ext_trig,                       // external event pins
	input  wire logic [NCONV-1:0]  int_trig,                       // on-chip event pulses
	input  wire logic [NCONV-1:0]  comp_in,                        // comparator, 1: input >= dac
	output logic [NCONV-1:0][3:0]  chan_sel,                       // analog channel select
	output logic [NCONV-1:0][2:0]  ext_mux_sel,                    // external mux select
	output logic [NCONV-1:0][9:0]  dac_code,                       // trial code to dac
	output logic [NCONV-1:0]       sample_hold,                    // high while sampling
	output logic [NCONV-1:0]       power_up,                       // analog part powered
	output logic [NCONV-1:0]       srq_result,                     // result ready pulse
	output logic [NCONV-1:0]       srq_limit,                      // limit violation pulse
	output logic [NCONV-1:0]       xfer_req,                       // result waiting for transfer
	output logic [NCONV-1:0][15:0] xfer_data,                      // result to transfer
	input  wire logic [NCONV-1:0]  xfer_ack,                       // transfer taken
	output logic [15:0]            analog_pins_a_digital_disable,  // per pin, first group
	output logic [7:0]             analog_pins_b_digital_disable   // per pin, second group
);
	// configuration and state
	logic [31:0]       ctrl      [NCONV];
	logic [31:0]       timing    [NCONV];
	logic [31:0]       limit     [NCONV];
	logic [15:0]       par_mask  [NCONV];
	logic [15:0]       par_pend  [NCONV];
	logic [7:0]        wfr       [NCONV];
	logic [9:0]        ins_entry [NCONV];
	logic              ins_pend  [NCONV];
	logic [9:0]        q_mem     [NCONV][QDEPTH];
	logic [1:0]        q_wp      [NCONV];
	logic [1:0]        q_rp      [NCONV];
	logic [2:0]        q_cnt     [NCONV];
	logic              sync_en;
	conv_state_e       st        [NCONV];
	logic [7:0]        cnt       [NCONV];
	logic [3:0]        bidx      [NCONV];
	logic [9:0]        sar       [NCONV];
	logic [2:0]        cur_tgt   [NCONV];
	logic [ACC_W-1:0]  res_val   [NCONV][NRES];
	logic [NRES-1:0]   res_valid [NCONV];
	logic [2:0]        wp        [NCONV];
	logic [2:0]        rp        [NCONV];
	logic [2:0]        last_idx  [NCONV];
	logic              lim_flag  [NCONV];
	logic [NCONV-1:0]  comp_m, comp_s, ext_m, ext_s, ext_d;
	// combinational
	logic              cand_v    [NCONV];
	logic [1:0]        cand_src  [NCONV];
	logic [9:0]        cand_ent  [NCONV];
	logic [3:0]        par_first [NCONV];
	logic [NCONV-1:0]  go, trig, store_go, blocked, sw_start;
	logic [2:0]        tgt_idx   [NCONV];
	logic [ACC_W-1:0]  new_res   [NCONV];
	logic [NRES-1:0]   rd_clr    [NCONV];
	logic              out_lim   [NCONV];
	logic              wr_fire, rd_fire, w_ok, r_ok;
	logic [31:0]       next_rdata;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) m[8*b +: 8] = nw[8*b +: 8];
		end
		return m;
	endfunction

	// mapped when aligned, in range and one of the listed offsets
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		logic [6:0] o;
		o = a[6:0];
		if (a[1:0] != 2'h0 || a[ADDR_W-1:9] != 3'h0) return 1'b0;
		if (a[GLOB_BIT]) return !a[CONV_BIT] && o <= OFF_SYNC;
		return o <= OFF_FIFO_OUT || (o >= OFF_RESULT && o < OFF_RESULT + 7'(4 * NRES));
	endfunction

	// bus handshakes: write address and data are taken together once both are up
	assign wr_fire = awvalid && wvalid && !bvalid;
	assign awready = wvalid && !bvalid;
	assign wready  = awvalid && !bvalid;
	assign arready = !rvalid;
	assign rd_fire = arvalid && !rvalid;
	assign w_ok    = mapped(awaddr);
	assign r_ok    = mapped(araddr);

	// comparator and event pins cross two flops; edge detect compares the second against a third
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			comp_m <= '0;
			comp_s <= '0;
			ext_m  <= '0;
			ext_s  <= '0;
			ext_d  <= '0;
		end else begin
			comp_m <= comp_in;
			comp_s <= comp_m;
			ext_m  <= ext_trig;
			ext_s  <= ext_m;
			ext_d  <= ext_s;
		end
	end

	// arbitration, trigger and result path decode
	always_comb begin
		for (int c = 0; c < NCONV; c++) begin
			logic [1:0] bp;
			logic [1:0] tsel;
			bp   = 2'h0;
			tsel = ctrl[c][CTRL_TRIG +: 2];
			par_first[c] = 4'h0;
			for (int i = 15; i >= 0; i--) begin
				if (par_pend[c][i]) par_first[c] = 4'(i);  // lowest channel first
			end
			cand_v[c]   = 1'b0;
			cand_src[c] = SRC_PAR;
			cand_ent[c] = '0;
			// strict greater keeps the lower source index on a tie
			if (par_pend[c] != 16'h0) begin
				cand_v[c]   = 1'b1;
				bp          = ctrl[c][CTRL_PRIO +: 2];
				cand_ent[c] = {par_first[c][2:0], 3'(ctrl[c][CTRL_PRIO +: 2]), par_first[c]};
			end
			if (q_cnt[c] != 3'h0 && (!cand_v[c] || ctrl[c][CTRL_PRIO+2 +: 2] > bp)) begin
				cand_v[c]   = 1'b1;
				bp          = ctrl[c][CTRL_PRIO+2 +: 2];
				cand_src[c] = SRC_QUEUE;
				cand_ent[c] = q_mem[c][q_rp[c]];  // oldest entry first
			end
			if (ins_pend[c] && (!cand_v[c] || ctrl[c][CTRL_PRIO+4 +: 2] > bp)) begin
				cand_v[c]   = 1'b1;
				cand_src[c] = SRC_INS;
				cand_ent[c] = ins_entry[c];
			end
			// parallel entries use the channel low bits as target and the mux as zero
			if (cand_src[c] == SRC_PAR) cand_ent[c][6:4] = 3'h0;
			sw_start[c] = wr_fire && w_ok && !awaddr[GLOB_BIT] && awaddr[CONV_BIT] == c[0]
				&& awaddr[6:0] == OFF_START && wdata[0];
			trig[c] = sw_start[c]
				|| ((tsel == TRIG_EXT || tsel == TRIG_ANY) && ext_s[c] && !ext_d[c])
				|| ((tsel == TRIG_INT || tsel == TRIG_ANY) && int_trig[c]);
			new_res[c] = ctrl[c][CTRL_RES8] ? ACC_W'(sar[c][9:2]) : ACC_W'(sar[c]);
			tgt_idx[c] = ctrl[c][CTRL_FIFO] ? wp[c] : cur_tgt[c];
			rd_clr[c]  = '0;
			if (rd_fire && r_ok && !araddr[GLOB_BIT] && araddr[CONV_BIT] == c[0]) begin
				if (araddr[6:0] >= OFF_RESULT) rd_clr[c][araddr[4:2]] = 1'b1;
				if (araddr[6:0] == OFF_FIFO_OUT) rd_clr[c][rp[c]] = 1'b1;
			end
			if (xfer_req[c] && xfer_ack[c]) rd_clr[c][last_idx[c]] = 1'b1;
			// an unread protected register holds the result back
			blocked[c]  = res_valid[c][tgt_idx[c]] && wfr[c][tgt_idx[c]]
				&& !rd_clr[c][tgt_idx[c]];
			store_go[c] = st[c] == ST_STORE && !blocked[c];
			out_lim[c]  = new_res[c][9:0] < limit[c][9:0] || new_res[c][9:0] > limit[c][25:16];
		end
		// both idle and both requesting before either starts when locked
		for (int c = 0; c < NCONV; c++) begin
			go[c] = st[c] == ST_IDLE && cand_v[c] && (!sync_en
				|| (st[0] == ST_IDLE && st[1] == ST_IDLE && cand_v[0] && cand_v[1]));
		end
	end

	// software configuration registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_en <= 1'b0;
			analog_pins_a_digital_disable <= '0;
			analog_pins_b_digital_disable <= '0;
			for (int c = 0; c < NCONV; c++) begin
				ctrl[c]     <= CTRL_RESET;
				timing[c]   <= TIMING_RESET;
				limit[c]    <= LIMIT_RESET;
				par_mask[c] <= '0;
				wfr[c]      <= '0;
			end
		end else if (wr_fire && w_ok) begin
			if (awaddr[GLOB_BIT]) begin
				unique case (awaddr[6:0])
					OFF_DIDIS_A: analog_pins_a_digital_disable <= 16'(merge(32'(
						analog_pins_a_digital_disable), wdata, wstrb));
					OFF_DIDIS_B: analog_pins_b_digital_disable <= 8'(merge(32'(
						analog_pins_b_digital_disable), wdata, wstrb));
					OFF_SYNC:    if (wstrb[0]) sync_en <= wdata[0];
					default:     ;
				endcase
			end else begin
				for (int c = 0; c < NCONV; c++) begin
					if (awaddr[CONV_BIT] == c[0]) begin
						unique case (awaddr[6:0])
							OFF_CTRL:     ctrl[c]   <= merge(ctrl[c], wdata, wstrb) & CTRL_WMASK;
							OFF_TIMING:   timing[c] <= merge(timing[c], wdata, wstrb)
								& TIMING_WMASK;
							OFF_LIMIT:    limit[c]  <= merge(limit[c], wdata, wstrb)
								& LIMIT_WMASK;
							OFF_PAR_MASK: par_mask[c] <= 16'(merge(32'(par_mask[c]), wdata, wstrb))
								& CHAN_MASK[c];
							OFF_WFR:      wfr[c] <= 8'(merge(32'(wfr[c]), wdata, wstrb));
							default:      ;
						endcase
					end
				end
			end
		end
	end

	// request sources: parallel pending bits, insert slot, queue
	always_ff @(posedge aclk) begin
		for (int c = 0; c < NCONV; c++) begin
			logic push, ins_wr, chan_ok;
			chan_ok = {1'b0, wdata[3:0]} < CHAN_COUNT[c];
			push    = wr_fire && w_ok && !awaddr[GLOB_BIT] && awaddr[CONV_BIT] == c[0]
				&& awaddr[6:0] == OFF_QUEUE && chan_ok && q_cnt[c] != 3'(QDEPTH);
			ins_wr  = wr_fire && w_ok && !awaddr[GLOB_BIT] && awaddr[CONV_BIT] == c[0]
				&& awaddr[6:0] == OFF_INSERT && chan_ok;
			if (!aresetn) begin
				par_pend[c]  <= '0;
				ins_pend[c]  <= 1'b0;
				ins_entry[c] <= '0;
				q_wp[c]      <= '0;
				q_rp[c]      <= '0;
				q_cnt[c]     <= '0;
				for (int e = 0; e < QDEPTH; e++) q_mem[c][e] <= '0;
			end else begin
				// granted channel drops out, later channels stay armed
				par_pend[c] <= (par_pend[c] & ~((go[c] && cand_src[c] == SRC_PAR)
					? 16'h1 << par_first[c] : 16'h0)) | (trig[c] ? par_mask[c] : 16'h0);
				if (ins_wr) begin
					ins_pend[c]  <= 1'b1;  // a new insert wins over the grant clearing it
					ins_entry[c] <= {wdata[10:8], wdata[6:4], wdata[3:0]};
				end else if (go[c] && cand_src[c] == SRC_INS) begin
					ins_pend[c] <= 1'b0;
				end
				if (push) begin
					q_mem[c][q_wp[c]] <= {wdata[10:8], wdata[6:4], wdata[3:0]};
					q_wp[c] <= q_wp[c] + 2'h1;
				end
				if (go[c] && cand_src[c] == SRC_QUEUE) q_rp[c] <= q_rp[c] + 2'h1;
				q_cnt[c] <= q_cnt[c] + 3'(push) - 3'(go[c] && cand_src[c] == SRC_QUEUE);
			end
		end
	end

	// conversion engine: sample, successive approximation, store
	always_ff @(posedge aclk) begin
		for (int c = 0; c < NCONV; c++) begin
			if (!aresetn) begin
				st[c]          <= ST_IDLE;
				cnt[c]         <= '0;
				bidx[c]        <= '0;
				sar[c]         <= '0;
				cur_tgt[c]     <= '0;
				chan_sel[c]    <= '0;
				ext_mux_sel[c] <= '0;
			end else begin
				unique case (st[c])
					ST_IDLE: if (go[c]) begin
						st[c]          <= ST_SAMPLE;
						cnt[c]         <= timing[c][7:0];
						chan_sel[c]    <= cand_ent[c][3:0];
						ext_mux_sel[c] <= cand_ent[c][6:4];
						cur_tgt[c]     <= cand_ent[c][9:7];
					end
					ST_SAMPLE: if (cnt[c] == 8'h0) begin
						st[c]   <= ST_CONV;
						cnt[c]  <= timing[c][15:8];
						bidx[c] <= 4'(RES_W - 1);
						sar[c]  <= SAR_FIRST;
					end else begin
						cnt[c] <= cnt[c] - 8'h1;
					end
					ST_CONV: if (cnt[c] != 8'h0) begin
						cnt[c] <= cnt[c] - 8'h1;
					end else begin
						if (!comp_s[c]) sar[c][bidx[c]] <= 1'b0;  // trial too high
						if (bidx[c] == (ctrl[c][CTRL_RES8] ? LAST_BIT_SHORT : LAST_BIT_FULL)) begin
							st[c] <= ST_STORE;
						end else begin
							bidx[c] <= bidx[c] - 4'h1;
							sar[c][bidx[c] - 4'h1] <= 1'b1;
							cnt[c]  <= timing[c][15:8];
						end
					end
					ST_STORE: if (store_go[c]) st[c] <= ST_IDLE;
					default: st[c] <= ST_IDLE;
				endcase
			end
		end
	end

	// result registers; a store in the same cycle as a read-clear wins
	always_ff @(posedge aclk) begin
		for (int c = 0; c < NCONV; c++) begin
			if (!aresetn) begin
				res_valid[c] <= '0;
				wp[c]        <= '0;
				rp[c]        <= '0;
				last_idx[c]  <= '0;
				lim_flag[c]  <= 1'b0;
				srq_result[c] <= 1'b0;
				srq_limit[c]  <= 1'b0;
				for (int r = 0; r < NRES; r++) res_val[c][r] <= '0;
			end else begin
				res_valid[c] <= (res_valid[c] & ~rd_clr[c])
					| (store_go[c] ? NRES'(1) << tgt_idx[c] : '0);
				if (store_go[c]) begin
					// accumulate onto an unread result, otherwise replace
					res_val[c][tgt_idx[c]] <= (ctrl[c][CTRL_ACC] && res_valid[c][tgt_idx[c]]
						&& !rd_clr[c][tgt_idx[c]]) ? res_val[c][tgt_idx[c]] + new_res[c]
						: new_res[c];
					last_idx[c] <= tgt_idx[c];
					if (ctrl[c][CTRL_FIFO]) wp[c] <= wp[c] + 3'h1;
				end
				if (rd_fire && r_ok && !araddr[GLOB_BIT] && araddr[CONV_BIT] == c[0]
					&& araddr[6:0] == OFF_FIFO_OUT && res_valid[c][rp[c]])
					rp[c] <= rp[c] + 3'h1;
				// limit flag is cleared by writing one to status, a new hit wins
				if (store_go[c] && out_lim[c]) lim_flag[c] <= 1'b1;
				else if (wr_fire && w_ok && !awaddr[GLOB_BIT] && awaddr[CONV_BIT] == c[0]
					&& awaddr[6:0] == OFF_STATUS && wdata[1]) lim_flag[c] <= 1'b0;
				srq_result[c] <= store_go[c] && ctrl[c][CTRL_SRQ_RES];
				srq_limit[c]  <= store_go[c] && out_lim[c] && ctrl[c][CTRL_SRQ_LIM];
			end
		end
	end

	// analog side and transfer controller views of the state
	always_comb begin
		for (int c = 0; c < NCONV; c++) begin
			dac_code[c]    = sar[c];
			sample_hold[c] = st[c] == ST_SAMPLE;
			power_up[c]    = st[c] != ST_IDLE;
			xfer_req[c]    = ctrl[c][CTRL_XFER] && res_valid[c][last_idx[c]];
			xfer_data[c]   = res_val[c][last_idx[c]];
		end
	end

	// read data selection
	always_comb begin
		logic [6:0] o;
		logic       c;
		o = araddr[6:0];
		c = araddr[CONV_BIT];
		next_rdata = 32'h0;
		if (araddr[GLOB_BIT]) begin
			if (o == OFF_DIDIS_A) next_rdata = 32'(analog_pins_a_digital_disable);
			if (o == OFF_DIDIS_B) next_rdata = 32'(analog_pins_b_digital_disable);
			if (o == OFF_SYNC)    next_rdata = 32'(sync_en);
		end else if (o >= OFF_RESULT) begin
			next_rdata = {res_valid[c][o[4:2]], 15'h0, res_val[c][o[4:2]]};
		end else begin
			unique case (o)
				OFF_CTRL:     next_rdata = ctrl[c];
				OFF_TIMING:   next_rdata = timing[c];
				OFF_PAR_MASK: next_rdata = 32'(par_mask[c]);
				OFF_INSERT:   next_rdata = {ins_pend[c], 20'h0, ins_entry[c][9:7], 1'b0,
					ins_entry[c][6:4], ins_entry[c][3:0]};
				OFF_QUEUE:    next_rdata = 32'(q_cnt[c]);
				OFF_LIMIT:    next_rdata = limit[c];
				OFF_STATUS:   next_rdata = {par_pend[c], 6'h0, ins_pend[c], q_cnt[c],
					chan_sel[c], lim_flag[c], st[c] != ST_IDLE};
				OFF_WFR:      next_rdata = 32'(wfr[c]);
				OFF_FIFO_OUT: next_rdata = {res_valid[c][rp[c]], 15'h0, res_val[c][rp[c]]};
				default:      next_rdata = 32'h0;
			endcase
		end
	end

	// bus response channels
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
			rvalid <= 1'b0;
			rresp  <= RESP_OKAY;
			rdata  <= '0;
		end else begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= w_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
			if (rd_fire) begin
				rvalid <= 1'b1;
				rresp  <= r_ok ? RESP_OKAY : RESP_SLVERR;
				rdata  <= r_ok ? next_rdata : 32'h0;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/analog_front.sv ====
/* comparator model of the analog side; inputs come from the design ports */
`default_nettype none
module analog_front (
	input  wire logic            aclk,        // system clock
	input  wire logic [1:0][3:0] chan_sel,    // channel select
	input  wire logic [1:0][2:0] ext_mux_sel, // external mux select
	input  wire logic [1:0][9:0] dac_code,    // trial code
	input  wire logic [1:0]      sample_hold, // sampling
	output logic      [1:0]      comp_in      // 1: input >= dac
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0][9:0] held;
	// level tracks channel and mux while sampling, then holds like the capacitor
	always_ff @(posedge aclk)
		for (int c = 0; c < 2; c++)
			if (sample_hold[c])
				held[c] <= {chan_sel[c], ext_mux_sel[c], 3'h5};
	always_comb
		for (int c = 0; c < 2; c++)
			comp_in[c] = held[c] >= dac_code[c];
endmodule
`default_nettype wire

// ==== tb/seq_checker_assertions.sv ====
/* port checker for the sequencer; bound into the design top */
`default_nettype none
module seq_checker (
	input wire logic            aclk, aresetn, awvalid, wvalid, bvalid, // bus
	input wire logic [1:0]      sample_hold, power_up, srq_result,      // conversion
	input wire logic [1:0][3:0] chan_sel,                               // channel
	input wire logic [1:0][2:0] ext_mux_sel,                            // mux
	input wire logic [1:0][9:0] dac_code,                               // trial code
	input wire logic [15:0]     analog_pins_a_digital_disable          // pins
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_pw; sample_hold[0] |-> power_up[0]; endproperty
	a_pw: assert property (p_pw) else $error("sampling while down");
	property p_gr; $rose(power_up[0]) |-> sample_hold[0]; endproperty
	a_gr: assert property (p_gr) else $error("wake without sample");
	property p_sar; $fell(sample_hold[1]) |-> dac_code[1] == 10'h200; endproperty
	a_sar: assert property (p_sar) else $error("bad first trial");
	property p_ch0; power_up[0] |-> chan_sel[0] < 4'hB; endproperty
	a_ch0: assert property (p_ch0) else $error("channel out of range");
	property p_ch1; power_up[1] |-> chan_sel[1] < 4'h5; endproperty
	a_ch1: assert property (p_ch1) else $error("channel out of range");
	property p_mx; power_up[0] && $past(power_up[0]) |-> $stable(ext_mux_sel[0]); endproperty
	a_mx: assert property (p_mx) else $error("mux moved mid conversion");
	property p_srq; srq_result[0] |=> !srq_result[0]; endproperty
	a_srq: assert property (p_srq) else $error("request not a pulse");
	property p_cv; $fell(sample_hold[0]) |-> power_up[0] [*8]; endproperty
	a_cv: assert property (p_cv) else $error("conversion too short");
	property p_dis;
		!$stable(analog_pins_a_digital_disable) |-> $past(awvalid && wvalid && !bvalid);
	endproperty
	a_dis: assert property (p_dis) else $error("disable changed alone");
endmodule
bind adc_request_sequencer seq_checker chk_u (.*);
`default_nettype wire

// ==== tb/testbench.sv ====
/* self-checking bench: axi4-lite master, read monitor, analog model */
`default_nettype none
module testbench import adc_request_sequencer_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0;
	logic rready = '0, awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, r, seed = 32'hEEABFD10;
	logic [3:0] wstrb = 4'hF;
	logic [2:0] awprot = '0, arprot = '0;
	logic [1:0] ext_trig = '0, int_trig = '0, xfer_ack = '0, comp_in, bresp, rresp;
	logic [1:0] sample_hold, power_up, srq_result, srq_limit, xfer_req;
	logic [1:0][3:0] chan_sel;
	logic [1:0][2:0] ext_mux_sel;
	logic [1:0][9:0] dac_code;
	logic [1:0][15:0] xfer_data;
	logic [15:0] analog_pins_a_digital_disable;
	logic [7:0] analog_pins_b_digital_disable;
	logic [33:0] exp_q[$];
	int fail_count = 0, tests_run = 0;
	adc_request_sequencer dut_u (.*);
	analog_front far_u (.*);
	always #10 aclk = ~aclk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic results();
		$display("tests %0d fails %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic tmo();
		fail_count++;
		$display("mismatch t=%0t timeout", $time);
		results();
	endtask
	// bus cycles: payload held until its ready edge, answer taken at its valid edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge aclk);
		{awaddr, wdata, awvalid, wvalid} <= {a, d, 2'h3};
		i = 0;
		do begin @(posedge aclk); i++; end while (!(awready && wready) && i < 99);
		{awvalid, wvalid, bready} <= 3'h1;
		do begin @(posedge aclk); i++; end while (!bvalid && i < 199);
		bready <= 1'b0;
		if (i >= 199) tmo();
	endtask
	task automatic rd(input logic [11:0] a, input logic [33:0] e);
		int i;
		exp_q.push_back(e);
		@(posedge aclk);
		{araddr, arvalid} <= {a, 1'b1};
		i = 0;
		do begin @(posedge aclk); i++; end while (!arready && i < 99);
		{arvalid, rready} <= 2'h1;
		do begin @(posedge aclk); i++; end while (!rvalid && i < 199);
		rready <= 1'b0;
		if (i >= 199) tmo();
	endtask
	// queue word and expected stored value, valid flag set
	task automatic qp(input logic [11:0] a, input logic [3:0] c, input logic [2:0] m, t);
		wr(a, {21'h0, t, 1'b0, m, c});
	endtask
	task automatic rr(input logic [11:0] a, input logic [3:0] c, input logic [2:0] m);
		rd(a, {RESP_OKAY, 22'h200000, c, m, 3'h5});
	endtask
	// both converters must sit idle 8 cycles; back-to-back grants never leave a gap that long
	task automatic idle();
		int i, n;
		n = 0;
		for (i = 0; i < 3000 && n < 8; i++) begin
			@(posedge aclk);
			n = (power_up === 2'h0) ? n + 1 : 0;
		end
		if (n < 8) tmo();
	endtask
	// every write in this bench targets a mapped register, so each answer must be okay
	always @(posedge aclk) if (bvalid && bready) begin
		tests_run++;
		if (bresp !== RESP_OKAY) begin
			fail_count++;
			$display("mismatch t=%0t write answer %h", $time, bresp);
		end
	end
	// oldest note against each accepted read
	always @(posedge aclk) if (rvalid && rready) begin
		tests_run++;
		if (exp_q.size() == 0 || {rresp, rdata} !== exp_q[0]) begin
			fail_count++;
			$display("mismatch t=%0t read %h", $time, {rresp, rdata});
		end
		if (exp_q.size() > 0) void'(exp_q.pop_front());
	end
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h004, {RESP_OKAY, TIMING_RESET});
		rd(12'h098, {RESP_OKAY, LIMIT_RESET});
		rd(12'h0FC, {RESP_SLVERR, 32'h0});
		r = xs();
		wr(12'h100, r);
		wr(12'h104, r);
		rd(12'h100, {RESP_OKAY, 16'h0, r[15:0]});
		rd(12'h104, {RESP_OKAY, 24'h0, r[7:0]});
		r = xs() % 11;
		qp(12'h014, r[3:0], 3'h2, 3'h0);
		qp(12'h014, 4'hA, 3'h7, 3'h1);
		qp(12'h014, 4'h0, 3'h0, 3'h1);
		qp(12'h094, 4'h4, 3'h3, 3'h0);
		idle();
		rr(12'h040, r[3:0], 3'h2);
		rr(12'h044, 4'h0, 3'h0);
		rr(12'h0C0, 4'h4, 3'h3);
		wr(12'h008, 32'h6);
		wr(12'h00C, 32'h1);
		qp(12'h010, 4'h3, 3'h2, 3'h4);
		idle();
		rr(12'h044, 4'h1, 3'h0);
		rr(12'h048, 4'h2, 3'h0);
		rr(12'h050, 4'h3, 3'h2);
		wr(12'h000, 32'h4001);
		qp(12'h014, 4'h6, 3'h1, 3'h3);
		idle();
		rd(12'h04C, {RESP_OKAY, 32'h80000063});
		results();
	end
endmodule
`default_nettype wire
